// ### inc/pwm_stepper_pkg.sv
// Notes on behaviour
// - stepper mode takes duty from bits 9..0 only; bits 15..13, 11, 10 ignored.
// - after cycle match output stays high until duty match; zero duty gives no high.
// - 16-bit mode outputs 0,1 use duty 0,1; stepper: duty 0 steered by select bit.
// - 16-bit mode outputs 2,3 use duty 2,3; stepper: duty 2 steered by select bit.
// - each duty buffer copies bit for bit into its active duty register on cycle match.
// - setting count_run starts the counter on the selected prescaled clock.
// - cycle match copies buffers, sets match flag, requests service when enabled.
// - cycle match resets the counter to zero and counting continues.
// - 16-bit mode: output high at cycle match, low at its duty match.
// - stepper mode cycle compare uses lower 10 bits of counter and cycle register.
// - stepper mode: only selected outputs go high at cycle match; selected falls at duty.
// - clearing count_run resets and halts counter, drives all outputs low at once.
// - cycle and buffer registers take only 16-bit accesses; byte writes ignored, byte reads return zero.
// - 8-bit registers take byte access; 16-bit read returns all ones in low byte.
// - buffer write right after cycle match updates buffer and active duty, not output.
// - output enable bits 3..0 enable their pins when 1; reset to 0.
// - cycle register resets to all ones; host never writes zero or while running.
// - while count_run is 0, counter and active duty registers held at zero.
package pwm_stepper_pkg;

  // ****************************************
  // register indices
  // ****************************************
  localparam logic [2:0] ADDR_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_OE     = 3'h1;
  localparam logic [2:0] ADDR_CYCLE  = 3'h2;
  localparam logic [2:0] ADDR_BUF0   = 3'h3;
  localparam int         NUM_CHAN    = 4;

  // ****************************************
  // timer_ctrl_reg field positions
  // ****************************************
  localparam int POS_RUN   = 7;
  localparam int POS_CMF   = 6;
  localparam int POS_IE    = 5;
  localparam int POS_SMODE = 4;
  localparam int POS_CKS   = 0;
  localparam int POS_OTS   = 12;
  localparam int STEP_BITS = 10;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] CYCLE_RESET = 16'hffff;
  localparam logic [15:0] DUTY_RESET  = 16'h0000;
  localparam logic [7:0]  LOW_FILL    = 8'hff;

endpackage : pwm_stepper_pkg

// ### verilog/pwm_prescaler.sv
`timescale 1ns/10ps
module pwm_prescaler (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // control
  input  wire logic       run,
  input  wire logic [2:0] cks,
  // tick
  output logic            tick
);
  import pwm_stepper_pkg::*;

  logic [3:0] div_r;
  logic [3:0] mask;

  // ****************************************
  // divider mask per clock select
  // ****************************************
  always_comb begin
    unique case (cks)
      3'h0:    mask = 4'h0;
      3'h1:    mask = 4'h1;
      3'h2:    mask = 4'h3;
      3'h3:    mask = 4'h7;
      default: mask = 4'hf;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 4'h0;
    end else if (!run) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  assign tick = run && ((div_r & mask) == mask);

endmodule : pwm_prescaler

// ### verilog/pwm_stepper_timer.sv
`timescale 1ns/10ps
module pwm_stepper_timer (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // register access
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wide,
  input  wire logic [2:0]  bus_addr,
  input  wire logic [15:0] bus_wdata,
  output logic      [15:0] bus_rdata,
  // service request
  output logic             match_req,
  // waveform pins
  output logic             wave_out_0,
  output logic             wave_out_1,
  output logic             wave_out_2,
  output logic             wave_out_3
);
  import pwm_stepper_pkg::*;

  // ****************************************
  // helper functions
  // ****************************************
  function automatic logic [15:0] eff_duty(input logic smode, input logic [15:0] own,
                                           input logic [15:0] pair);
    eff_duty = smode ? {6'h00, pair[STEP_BITS-1:0]} : own;
  endfunction : eff_duty

  function automatic logic chosen(input logic smode, input logic [15:0] pair, input int ch);
    chosen = !smode || (pair[POS_OTS] == ch[0]);
  endfunction : chosen

  function automatic logic [15:0] cmp_val(input logic smode, input logic [15:0] v);
    cmp_val = smode ? {6'h00, v[STEP_BITS-1:0]} : v;
  endfunction : cmp_val

  function automatic logic [7:0] wr_byte(input logic wide, input logic [15:0] d);
    wr_byte = wide ? d[15:8] : d[7:0];
  endfunction : wr_byte

  // ****************************************
  // state
  // ****************************************
  logic                run_r;
  logic                cmf_r;
  logic                ie_r;
  logic                smode_r;
  logic [2:0]          cks_r;
  logic [NUM_CHAN-1:0] oe_r;
  logic [15:0]         cyc_r;
  logic [15:0]         buf_r  [NUM_CHAN];
  logic [15:0]         duty_r [NUM_CHAN];
  logic [15:0]         cnt_r;
  logic [15:0]         cnt_inc;
  logic [NUM_CHAN-1:0] lvl_r;
  logic [NUM_CHAN-1:0] wave_r;
  logic [NUM_CHAN-1:0] start_lvl;
  logic [NUM_CHAN-1:0] fall;
  logic                match_d_r;
  logic                tick;
  logic                cyc_match;
  logic                frame_end;
  logic                wr_ctrl;
  logic                wr_oe;
  logic                wr_cyc;
  logic                wr_buf;
  logic [1:0]          buf_idx;
  logic [7:0]          wb;
  logic [7:0]          ctrl_byte;
  logic [15:0]         rdata_r;
  logic                req_r;

  // ****************************************
  // bus decode
  // ****************************************
  assign wb       = wr_byte(bus_wide, bus_wdata);
  assign wr_ctrl  = bus_wr && (bus_addr == ADDR_CTRL);
  assign wr_oe    = bus_wr && (bus_addr == ADDR_OE);
  assign wr_cyc   = bus_wr && bus_wide && (bus_addr == ADDR_CYCLE);
  assign wr_buf   = bus_wr && bus_wide && (bus_addr >= ADDR_BUF0) && (bus_addr != 3'h7);
  assign buf_idx  = 2'(bus_addr - ADDR_BUF0);
  assign ctrl_byte = {run_r, cmf_r, ie_r, smode_r, 1'b0, cks_r};

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      run_r   <= 1'b0;
      ie_r    <= 1'b0;
      smode_r <= 1'b0;
      cks_r   <= 3'h0;
    end else if (wr_ctrl) begin
      run_r   <= wb[POS_RUN];
      ie_r    <= wb[POS_IE];
      smode_r <= wb[POS_SMODE];
      cks_r   <= wb[POS_CKS +: 3];
    end
  end

  // match flag: only 0 clears it, a new match wins over the clear
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmf_r <= 1'b0;
    end else if (frame_end) begin
      cmf_r <= 1'b1;
    end else if (wr_ctrl && !wb[POS_CMF]) begin
      cmf_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      oe_r <= 4'h0;
    end else if (wr_oe) begin
      oe_r <= wb[NUM_CHAN-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_r <= CYCLE_RESET;
    end else if (wr_cyc) begin
      cyc_r <= bus_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        buf_r[i] <= DUTY_RESET;
      end
    end else if (wr_buf) begin
      buf_r[buf_idx] <= bus_wdata;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 16'h0000;
    end else if (bus_rd) begin
      unique case (bus_addr)
        ADDR_CTRL:  rdata_r <= bus_wide ? {ctrl_byte, LOW_FILL} : {8'h00, ctrl_byte};
        ADDR_OE:    rdata_r <= bus_wide ? {4'h0, oe_r, LOW_FILL} : {12'h000, oe_r};
        ADDR_CYCLE: rdata_r <= bus_wide ? cyc_r : 16'h0000;
        3'h3, 3'h4, 3'h5, 3'h6: rdata_r <= bus_wide ? buf_r[buf_idx] : 16'h0000;
        default:    rdata_r <= 16'h0000;
      endcase
    end
  end

  // ****************************************
  // counter
  // ****************************************
  pwm_prescaler u_prescaler (
    .mclk  (mclk),
    .rst_b (rst_b),
    .run   (run_r),
    .cks   (cks_r),
    .tick  (tick)
  );

  assign cnt_inc   = cnt_r + 16'h0001;
  assign cyc_match = cmp_val(smode_r, cnt_r) == cmp_val(smode_r, cyc_r);
  assign frame_end = run_r && tick && cyc_match;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 16'h0000;
    end else if (!run_r) begin
      cnt_r <= 16'h0000;
    end else if (tick) begin
      cnt_r <= cyc_match ? 16'h0000 : cnt_inc;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      match_d_r <= 1'b0;
    end else begin
      match_d_r <= frame_end;
    end
  end

  // ****************************************
  // active duty registers
  // ****************************************
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        duty_r[i] <= DUTY_RESET;
      end
    end else if (!run_r) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        duty_r[i] <= DUTY_RESET;
      end
    end else if (frame_end) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        duty_r[i] <= buf_r[i];
      end
    end else if (match_d_r && wr_buf) begin
      duty_r[buf_idx] <= bus_wdata;
    end
  end

  // ****************************************
  // waveform levels
  // ****************************************
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      start_lvl[i] = chosen(smode_r, buf_r[i & 2], i)
                     && (eff_duty(smode_r, buf_r[i], buf_r[i & 2]) != 16'h0000);
      fall[i]      = eff_duty(smode_r, duty_r[i], duty_r[i & 2])
                     == cmp_val(smode_r, cnt_inc);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lvl_r <= 4'h0;
    end else if (!run_r) begin
      lvl_r <= 4'h0;
    end else if (tick) begin
      lvl_r <= cyc_match ? start_lvl : (lvl_r & ~fall);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wave_r <= 4'h0;
    end else begin
      wave_r <= run_r ? (lvl_r & oe_r) : 4'h0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      req_r <= 1'b0;
    end else begin
      req_r <= cmf_r && ie_r;
    end
  end

  assign bus_rdata  = rdata_r;
  assign match_req  = req_r;
  assign wave_out_0 = wave_r[0];
  assign wave_out_1 = wave_r[1];
  assign wave_out_2 = wave_r[2];
  assign wave_out_3 = wave_r[3];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_stop_outs_low: assert property (!run_r |=> wave_r == 4'h0)
    else $error("outputs not low while stopped");
  a_stop_cnt_zero: assert property (!run_r |=> cnt_r == 16'h0000 && duty_r[0] == 16'h0000)
    else $error("counter or duty not held at zero");
  a_match_clr_cnt: assert property (frame_end |=> cnt_r == 16'h0000)
    else $error("cycle match did not clear counter");
  a_match_copy_duty: assert property (frame_end |=> duty_r[3] == $past(buf_r[3]))
    else $error("buffer not copied on cycle match");
  a_match_sets_flag: assert property (frame_end |=> cmf_r ##1 (req_r == ie_r))
    else $error("match flag or request missing");
  a_cnt_steps: assert property (run_r && tick && !cyc_match |=> cnt_r == $past(cnt_inc))
    else $error("counter did not increment");
  a_zero_duty_low: assert property (frame_end && !smode_r && buf_r[1] == 16'h0000
                                    |=> !lvl_r[1] ##1 !wave_r[1])
    else $error("zero duty produced a high level");
  a_step_unsel_low: assert property (frame_end && smode_r && !buf_r[0][POS_OTS]
                                     |=> !lvl_r[1])
    else $error("unselected stepper output went high");
  a_step_sel_pair: assert property (frame_end && smode_r && buf_r[2][POS_OTS]
                                    |=> !lvl_r[2])
    else $error("unselected upper stepper output went high");
  a_duty_fall_low: assert property (run_r && tick && !cyc_match && !smode_r && fall[0]
                                    |=> !lvl_r[0])
    else $error("output did not fall at duty match");
  a_late_load: assert property (run_r && match_d_r && wr_buf && bus_addr == ADDR_BUF0
                                |=> duty_r[0] == $past(bus_wdata))
    else $error("late buffer write did not load active duty");
  a_req_level: assert property (cmf_r && ie_r |=> req_r)
    else $error("request not raised for set flag");
  a_oe_gate: assert property (!oe_r[2] |=> !wave_r[2])
    else $error("disabled output driven high");
  a_byte_ignored: assert property (bus_wr && !bus_wide && bus_addr == ADDR_CYCLE
                                   |=> $stable(cyc_r))
    else $error("byte write changed cycle register");

  c_frame_16: cover property (frame_end && !smode_r);
  c_frame_step: cover property (frame_end && smode_r);
  c_duty_fall: cover property (run_r && tick && !cyc_match && lvl_r[0] && fall[0]);
  c_late_write: cover property (match_d_r && wr_buf);

endmodule : pwm_stepper_timer

// ### testbench/pwm_load_model.sv
`timescale 1ns/10ps
// ****************************************
// load on the waveform pins: high-time meter
// ****************************************
module pwm_load_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // control
  input  wire logic        clr,
  // waveform pins
  input  wire logic        wave_out_0,
  input  wire logic        wave_out_1,
  input  wire logic        wave_out_2,
  input  wire logic        wave_out_3,
  // high cycles per pin, 16 bits each
  output logic      [63:0] hi_cnt
);
  logic [3:0] pins;

  assign pins = {wave_out_3, wave_out_2, wave_out_1, wave_out_0};

  // counts mclk edges at which each pin is high
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hi_cnt <= '0;
    end else if (clr) begin
      hi_cnt <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        hi_cnt[i*16 +: 16] <= hi_cnt[i*16 +: 16] + 16'(pins[i]);
      end
    end
  end
endmodule : pwm_load_model

// ### testbench/pwm_stepper_timer_tb_top.sv
`timescale 1ns/10ps
module pwm_stepper_timer_tb_top;
  import pwm_stepper_pkg::*;
  logic        mclk, rst_b, bus_wr, bus_rd, bus_wide, clr, match_req;
  logic        wave_out_0, wave_out_1, wave_out_2, wave_out_3;
  logic [2:0]  bus_addr;
  logic [15:0] bus_wdata, bus_rdata, rv;
  logic [63:0] hi_cnt;
  int          mismatches, total_checks;

  pwm_stepper_timer dut (.mclk(mclk), .rst_b(rst_b), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wide(bus_wide), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .match_req(match_req), .wave_out_0(wave_out_0),
    .wave_out_1(wave_out_1), .wave_out_2(wave_out_2), .wave_out_3(wave_out_3));
  pwm_load_model load (.mclk(mclk), .rst_b(rst_b), .clr(clr), .wave_out_0(wave_out_0),
    .wave_out_1(wave_out_1), .wave_out_2(wave_out_2), .wave_out_3(wave_out_3),
    .hi_cnt(hi_cnt));

  // ****************************************
  // helpers
  // ****************************************
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task wr(input logic [2:0] a, input logic w, input logic [15:0] d);
    @(negedge mclk);
    bus_addr  = a;
    bus_wide  = w;
    bus_wdata = d;
    bus_wr    = 1'b1;
    @(negedge mclk);
    bus_wr    = 1'b0;
  endtask : wr

  task rd(input logic [2:0] a, input logic w);
    @(negedge mclk);
    bus_addr = a;
    bus_wide = w;
    bus_rd   = 1'b1;
    @(negedge mclk);
    bus_rd   = 1'b0;
    @(negedge mclk);
    rv       = bus_rdata;
  endtask : rd

  // ****************************************
  // scenarios
  // ****************************************
  task reset_values;
    rd(ADDR_CTRL, 1'b1);
    check("ctrl reset", rv, 16'h00ff);
    rd(ADDR_OE, 1'b0);
    check("oe reset", rv, 16'h0000);
    rd(ADDR_CYCLE, 1'b1);
    check("cycle reset", rv, CYCLE_RESET);
    for (int i = 0; i < 4; i++) begin
      rd(3'(ADDR_BUF0 + i), 1'b1);
      check("buffer reset", rv, DUTY_RESET);
    end
  endtask : reset_values

  task access_kinds;
    wr(3'h4, 1'b1, 16'h1234);
    wr(3'h4, 1'b0, 16'h00ff);
    rd(3'h4, 1'b1);
    check("buffer after byte write", rv, 16'h1234);
    rd(3'h4, 1'b0);
    check("buffer byte read", rv, 16'h0000);
    wr(ADDR_OE, 1'b0, 16'h0005);
    rd(ADDR_OE, 1'b1);
    check("oe wide read", rv, 16'h05ff);
    wr(ADDR_OE, 1'b1, 16'h0a00);
    rd(ADDR_OE, 1'b0);
    check("oe byte read", rv, 16'h000a);
    rd(3'h7, 1'b1);
    check("unmapped read", rv, 16'h0000);
    wr(ADDR_CYCLE, 1'b0, 16'h0012);
    rd(ADDR_CYCLE, 1'b1);
    check("cycle after byte write", rv, CYCLE_RESET);
    wr(3'h7, 1'b1, 16'h00aa);
    rd(ADDR_BUF0, 1'b1);
    check("index 7 write ignored", rv, DUTY_RESET);
  endtask : access_kinds

  task run_case(input logic m, input logic [2:0] cks, input logic [3:0] oe,
                input logic [15:0] cyc, b0, b1, b2, b3);
    logic [15:0] b [4];
    int          dv, c, per, d, hi;
    b = '{b0, b1, b2, b3};
    wr(ADDR_CTRL, 1'b0, {8'h00, 3'b000, m, 1'b0, cks});
    wr(ADDR_OE, 1'b0, {12'h000, oe});
    wr(ADDR_CYCLE, 1'b1, cyc);
    for (int i = 0; i < 4; i++) begin
      wr(3'(ADDR_BUF0 + i), 1'b1, b[i]);
    end
    wr(ADDR_CTRL, 1'b0, {8'h00, 3'b101, m, 1'b0, cks});
    dv  = cks[2] ? 16 : (1 << cks[1:0]);
    c   = m ? int'(cyc[9:0]) : int'(cyc);
    per = (c + 1) * dv;
    repeat (3 * per) @(negedge mclk);
    clr = 1'b1;
    @(negedge mclk);
    clr = 1'b0;
    repeat (4 * per) @(negedge mclk);
    for (int i = 0; i < 4; i++) begin
      d  = (i % 2 == int'(b[i & 2][12])) ? int'(b[i & 2][9:0]) : 0;
      d  = m ? d : int'(b[i]);
      hi = oe[i] ? ((d > c) ? c + 1 : d) : 0;
      check("pin high time", hi_cnt[i*16 +: 16], 16'(4 * hi * dv));
    end
    check("match request", {15'h0000, match_req}, 16'h0001);
    rd(ADDR_CTRL, 1'b1);
    check("ctrl with flag", rv, {3'b111, m, 1'b0, cks, 8'hff});
    wr(ADDR_CTRL, 1'b0, 16'h0000);
    repeat (2) @(negedge mclk);
    check("pins after stop", {12'h000, wave_out_3, wave_out_2, wave_out_1, wave_out_0},
          16'h0000);
  endtask : run_case

  task buffer_update;
    int n;
    wr(ADDR_CTRL, 1'b0, 16'h0000);
    wr(ADDR_OE, 1'b0, 16'h0001);
    wr(ADDR_CYCLE, 1'b1, 16'h0009);
    for (int i = 0; i < 4; i++) begin
      wr(3'(ADDR_BUF0 + i), 1'b1, 16'h0003);
    end
    wr(ADDR_CTRL, 1'b0, 16'h0080);
    // lands in the cycle right after the first cycle match
    repeat (9) @(negedge mclk);
    wr(ADDR_BUF0, 1'b1, 16'h0006);
    wr(ADDR_CTRL, 1'b0, 16'h0080);
    n  = 0;
    rv = 16'h0000;
    while (!rv[14] && n < 20) begin
      rd(ADDR_CTRL, 1'b1);
      n++;
    end
    check("flag rise seen", {15'h0000, rv[14]}, 16'h0001);
    wr(ADDR_BUF0, 1'b1, 16'h0005);
    repeat (30) @(negedge mclk);
    clr = 1'b1;
    @(negedge mclk);
    clr = 1'b0;
    repeat (40) @(negedge mclk);
    check("updated duty time", hi_cnt[15:0], 16'h0014);
    wr(ADDR_CTRL, 1'b0, 16'h0000);
  endtask : buffer_update

  // ****************************************
  // clock, reset, watchdog, sequence
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    #100000;
    mismatches++;
    complete_run();
  end

  initial begin
    rst_b     = 1'b0;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    bus_wide  = 1'b0;
    bus_addr  = 3'h0;
    bus_wdata = 16'h0000;
    clr       = 1'b0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    reset_values();
    access_kinds();
    run_case(1'b0, 3'h0, 4'hf, 16'h0009, 16'h0003, 16'h0000, 16'h000c, 16'h0009);
    for (int k = 1; k < 5; k++) begin
      run_case(1'b0, 3'(k), 4'hb, 16'h0004, 16'h0002, 16'h0005, 16'h0001, 16'h0004);
    end
    run_case(1'b1, 3'h0, 4'hf, 16'hfc07, 16'hec03, 16'h0001, 16'h1005, 16'h0002);
    run_case(1'b1, 3'h5, 4'hf, 16'h0006, 16'h1002, 16'h0004, 16'h0000, 16'h0003);
    buffer_update();
    complete_run();
  end
endmodule : pwm_stepper_timer_tb_top
